// >>> logic/fault_autorecovery_sequencer.sv
// Fault auto-recovery sequencer: overload timer, supply recovery, soft-start,
// protection-pin event qualification and slope ramp gating.
// Assumes analog comparator levels arrive asynchronous to CLK and are
// synchronised here; SWITCH_ON is the sensed switch on-time, treated alike.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Overload indication raises the error flag and starts the fault timer.
// - Undervoltage lockout or a full-timer overload stops the gate pulses.
// - After a stop, idle at supply minimum; restart at the turn-on level.
// - Every restart runs soft-start, protective ones included.
// - Slope ramp follows the clock, connected only during the on-time.
// - Protection pin comparator may force auto-recovery.
// - Ignore the overvoltage comparator for a blanking delay after turn-off.
// - Accept a comparator high only if it lasts the validation time.
// - Four recorded protection-pin events trigger auto-recovery.
// - Events must fall in consecutive cycles; a quiet cycle restarts count.
// - Each peak-limit hit, full or reduced, asserts the overload flag.
// - Supply overvoltage, qualified by a delay, enters hiccup then resumes.
module fault_autorecovery_sequencer #(
  parameter int unsigned FAULT_CYC = recovery_pkg::FAULT_CYCLES,
  parameter int unsigned SOFT_CYC = recovery_pkg::SOFTSTART_CYCLES,
  parameter int unsigned BLANK_CYC = recovery_pkg::BLANK_CYCLES,
  parameter int unsigned VALID_CYC = recovery_pkg::VALID_CYCLES,
  parameter int unsigned OV_DELAY_CYC = recovery_pkg::SUPPLY_OV_DELAY_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic GATE_REQUEST,
  input wire logic SWITCH_ON,
  input wire logic PEAK_LIMIT_HIT,
  input wire logic PROTECTION_SENSE_PIN,
  input wire logic SUPPLY_OVERVOLTAGE,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic SUPPLY_STOP_LEVEL,
  input wire logic SUPPLY_TURNON_LEVEL,
  output logic GATE_DRIVE,
  output logic RAMP_CONNECT,
  output logic SOFT_START,
  output logic OVERLOAD_ERROR,
  output logic RECOVERY_ACTIVE
);

  localparam logic [recovery_pkg::CNT_W-1:0] FAULT_N = recovery_pkg::CNT_W'(FAULT_CYC);
  localparam logic [recovery_pkg::CNT_W-1:0] SOFT_N = recovery_pkg::CNT_W'(SOFT_CYC);
  localparam logic [recovery_pkg::CNT_W-1:0] BLANK_N = recovery_pkg::CNT_W'(BLANK_CYC);
  localparam logic [recovery_pkg::CNT_W-1:0] VALID_N = recovery_pkg::CNT_W'(VALID_CYC);
  localparam logic [recovery_pkg::CNT_W-1:0] OV_DELAY_N = recovery_pkg::CNT_W'(OV_DELAY_CYC);
  localparam logic [2:0] TRIP_N = 3'(recovery_pkg::TRIP_COUNT);
  // Last count of a down-counter, kept at counter width for clean compares
  localparam logic [recovery_pkg::CNT_W-1:0] CNT_ONE = recovery_pkg::CNT_W'(1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    recovery_pkg::sense_type s1;
    recovery_pkg::sense_type s2;
    recovery_pkg::phase_type phase;
    logic [recovery_pkg::CNT_W-1:0] fault_cnt;
    logic [recovery_pkg::CNT_W-1:0] soft_cnt;
    logic [recovery_pkg::CNT_W-1:0] blank_cnt;
    logic [recovery_pkg::CNT_W-1:0] high_cnt;
    logic [recovery_pkg::CNT_W-1:0] ov_cnt;
    logic on_prev;
    logic cycle_event;
    logic [2:0] events;
    recovery_pkg::drive_type out;
  } state_type;

  state_type st_r;
  state_type st_nxt;
  recovery_pkg::sense_type raw;

  assign raw = '{GATE_REQUEST, SWITCH_ON, PEAK_LIMIT_HIT, PROTECTION_SENSE_PIN,
                 SUPPLY_OVERVOLTAGE, SUPPLY_UNDERVOLTAGE_LOCKOUT,
                 SUPPLY_STOP_LEVEL, SUPPLY_TURNON_LEVEL};

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Timers step by one per clock (blank, soft, fault down; high-time, overvoltage up) so every delay is a plain cycle count
  always_comb begin
    logic turn_off;
    logic turn_on;
    logic blanked;
    logic validated;
    logic pin_trip;
    logic ov_trip;
    logic timer_trip;
    logic stop;
    turn_off = 1'b0;
    turn_on = 1'b0;
    blanked = 1'b0;
    validated = 1'b0;
    pin_trip = 1'b0;
    ov_trip = 1'b0;
    timer_trip = 1'b0;
    stop = 1'b0;
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.on_prev = st_r.s2.switch_on;
    turn_off = st_r.on_prev && !st_r.s2.switch_on;
    turn_on = !st_r.on_prev && st_r.s2.switch_on;

    // Blanking restarts at each turn-off; comparator is not looked at meanwhile
    if (turn_off) begin
      st_nxt.blank_cnt = BLANK_N;
    end else if (st_r.blank_cnt != recovery_pkg::CNT_RESET) begin
      st_nxt.blank_cnt = st_r.blank_cnt - 1'b1;
    end
    blanked = turn_off || (st_r.blank_cnt != recovery_pkg::CNT_RESET);

    // High duration is measured only outside blanking, during the off-time
    validated = 1'b0;
    if (blanked || st_r.s2.switch_on || !st_r.s2.overvoltage_detect) begin
      st_nxt.high_cnt = recovery_pkg::CNT_RESET;
    end else if (st_r.high_cnt + 1'b1 >= VALID_N) begin
      validated = 1'b1;
      st_nxt.high_cnt = st_r.high_cnt;
    end else begin
      st_nxt.high_cnt = st_r.high_cnt + 1'b1;
    end
    if (validated) begin
      st_nxt.cycle_event = 1'b1;
    end

    // Each new switching cycle closes the previous one's verdict
    pin_trip = 1'b0;
    if (turn_on) begin
      st_nxt.cycle_event = 1'b0;
      if (!st_r.cycle_event) begin
        st_nxt.events = recovery_pkg::EVENTS_RESET;
      end else if (st_r.events + 1'b1 >= TRIP_N) begin
        pin_trip = 1'b1;
        st_nxt.events = recovery_pkg::EVENTS_RESET;
      end else begin
        st_nxt.events = st_r.events + 1'b1;
      end
    end

    // Supply overvoltage must persist before it is believed
    ov_trip = 1'b0;
    if (!st_r.s2.supply_overvoltage) begin
      st_nxt.ov_cnt = recovery_pkg::CNT_RESET;
    end else if (st_r.ov_cnt + 1'b1 >= OV_DELAY_N) begin
      ov_trip = 1'b1;
    end else begin
      st_nxt.ov_cnt = st_r.ov_cnt + 1'b1;
    end

    // Error flag follows each limit hit; timer runs down while it stays up
    st_nxt.out.overload_error = st_r.s2.peak_limit_hit;
    timer_trip = 1'b0;
    if (!st_r.s2.peak_limit_hit || (st_r.phase != recovery_pkg::ST_RUN &&
        st_r.phase != recovery_pkg::ST_SOFT)) begin
      st_nxt.fault_cnt = FAULT_N;
    end else if (st_r.fault_cnt <= CNT_ONE) begin
      timer_trip = 1'b1;
    end else begin
      st_nxt.fault_cnt = st_r.fault_cnt - 1'b1;
    end

    stop = st_r.s2.supply_undervoltage_lockout || timer_trip || pin_trip || ov_trip;

    // Sequencer
    unique case (st_r.phase)
      recovery_pkg::ST_WAIT_ON: begin
        if (st_r.s2.supply_turnon_level && !st_r.s2.supply_undervoltage_lockout) begin
          st_nxt.phase = recovery_pkg::ST_SOFT;
          st_nxt.soft_cnt = SOFT_N;
        end
      end
      recovery_pkg::ST_SOFT: begin
        if (stop) begin
          st_nxt.phase = recovery_pkg::ST_STOPPED;
        end else if (st_r.soft_cnt <= CNT_ONE) begin
          st_nxt.phase = recovery_pkg::ST_RUN;
        end else begin
          st_nxt.soft_cnt = st_r.soft_cnt - 1'b1;
        end
      end
      recovery_pkg::ST_RUN: begin
        if (stop) begin
          st_nxt.phase = recovery_pkg::ST_STOPPED;
        end
      end
      recovery_pkg::ST_STOPPED: begin
        if (st_r.s2.supply_stop_level) begin
          st_nxt.phase = recovery_pkg::ST_IDLE;
        end
      end
      recovery_pkg::ST_IDLE: begin
        if (st_r.s2.supply_turnon_level && !st_r.s2.supply_overvoltage) begin
          st_nxt.phase = recovery_pkg::ST_SOFT;
          st_nxt.soft_cnt = SOFT_N;
        end
      end
      default: st_nxt.phase = recovery_pkg::ST_WAIT_ON;
    endcase

    // Outputs registered from the next phase, so drive drops with the stop
    st_nxt.out.soft_start = (st_nxt.phase == recovery_pkg::ST_SOFT);
    st_nxt.out.gate_drive = st_r.s2.gate_request &&
      (st_nxt.phase == recovery_pkg::ST_SOFT || st_nxt.phase == recovery_pkg::ST_RUN);
    st_nxt.out.ramp_connect = st_nxt.out.gate_drive && st_r.s2.switch_on;
    st_nxt.out.recovery_active = (st_nxt.phase == recovery_pkg::ST_STOPPED) ||
      (st_nxt.phase == recovery_pkg::ST_IDLE);
  end

  // Synchronous reset; power-on also acts as a fresh start-up
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign GATE_DRIVE = st_r.out.gate_drive;
  assign RAMP_CONNECT = st_r.out.ramp_connect;
  assign SOFT_START = st_r.out.soft_start;
  assign OVERLOAD_ERROR = st_r.out.overload_error;
  assign RECOVERY_ACTIVE = st_r.out.recovery_active;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_stopped;
    st_r.phase == recovery_pkg::ST_STOPPED || st_r.phase == recovery_pkg::ST_IDLE;
  endsequence

  property p_lockout_stop;
    @(posedge CLK) disable iff (!RST_N)
      (st_r.s2.supply_undervoltage_lockout && st_r.phase == recovery_pkg::ST_RUN)
        |=> (!GATE_DRIVE && RECOVERY_ACTIVE);
  endproperty
  a_lockout_stop: assert property (p_lockout_stop) else $error("drive kept after lockout");

  property p_no_drive_stopped;
    @(posedge CLK) disable iff (!RST_N) s_stopped |-> !GATE_DRIVE;
  endproperty
  a_no_drive_stopped: assert property (p_no_drive_stopped) else $error("drive while stopped");

  property p_restart_soft;
    @(posedge CLK) disable iff (!RST_N)
      (st_r.phase == recovery_pkg::ST_IDLE && st_r.s2.supply_turnon_level &&
       !st_r.s2.supply_overvoltage) |=> SOFT_START;
  endproperty
  a_restart_soft: assert property (p_restart_soft) else $error("restart without soft-start");

  property p_ramp_on_only;
    @(posedge CLK) disable iff (!RST_N) RAMP_CONNECT |-> $past(st_r.s2.switch_on);
  endproperty
  a_ramp_on_only: assert property (p_ramp_on_only) else $error("ramp during off-time");

  property p_error_flag;
    @(posedge CLK) disable iff (!RST_N) st_r.s2.peak_limit_hit |=> OVERLOAD_ERROR;
  endproperty
  a_error_flag: assert property (p_error_flag) else $error("overload flag missed");

  property p_blank_ignore;
    @(posedge CLK) disable iff (!RST_N)
      (st_r.blank_cnt != recovery_pkg::CNT_RESET) |=> (st_r.high_cnt == recovery_pkg::CNT_RESET);
  endproperty
  a_blank_ignore: assert property (p_blank_ignore) else $error("sampled inside blanking");

  property p_events_bound;
    @(posedge CLK) disable iff (!RST_N) st_r.events < TRIP_N;
  endproperty
  a_events_bound: assert property (p_events_bound) else $error("event count overran");

  property p_quiet_clears;
    @(posedge CLK) disable iff (!RST_N)
      (!st_r.on_prev && st_r.s2.switch_on && !st_r.cycle_event)
        |=> (st_r.events == recovery_pkg::EVENTS_RESET);
  endproperty
  a_quiet_clears: assert property (p_quiet_clears) else $error("count kept after quiet cycle");

endmodule : fault_autorecovery_sequencer

`default_nettype wire

// >>> logic/recovery_pkg.sv
// Package for the fault auto-recovery sequencer: timing constants, states,
// and the packed carriers shared by the sequencer.
// Assumes a 20 MHz oscillator clock feeding the sequencer.
package recovery_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned FAULT_TIME_MS = 115;
  localparam int unsigned FAULT_CYCLES = (FAULT_TIME_MS * 1000000) / CLK_NS;
  localparam int unsigned SOFTSTART_MS = 4;
  localparam int unsigned SOFTSTART_CYCLES = (SOFTSTART_MS * 1000000) / CLK_NS;
  localparam int unsigned BLANK_NS = 1000;
  localparam int unsigned BLANK_CYCLES = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned VALID_NS = 500;
  localparam int unsigned VALID_CYCLES = (VALID_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SUPPLY_OV_DELAY_NS = 10000;
  localparam int unsigned SUPPLY_OV_DELAY_CYCLES = (SUPPLY_OV_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TRIP_COUNT = 4;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [2:0] EVENTS_RESET = 3'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT_ON = 3'b000,
    ST_SOFT = 3'b001,
    ST_RUN = 3'b010,
    ST_STOPPED = 3'b011,
    ST_IDLE = 3'b100
  } phase_type;

  typedef struct packed {
    logic gate_request;
    logic switch_on;
    logic peak_limit_hit;
    logic overvoltage_detect;
    logic supply_overvoltage;
    logic supply_undervoltage_lockout;
    logic supply_stop_level;
    logic supply_turnon_level;
  } sense_type;

  typedef struct packed {
    logic gate_drive;
    logic ramp_connect;
    logic soft_start;
    logic overload_error;
    logic recovery_active;
  } drive_type;

endpackage : recovery_pkg

// >>> sim/power_stage_model.sv
// Power stage model: PWM timing, supply levels and pin comparator.
// Assumes it shares the sequencer clock; bench sets the command inputs.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate_drive,
  input wire logic peak_cmd,
  input wire logic lockout_cmd,
  input wire logic supov_cmd,
  input wire logic [1:0] pin_mode,
  output var recovery_pkg::sense_type sense,
  output logic cycle_start
);
  // ----
  // Model
  // ----
  logic [4:0] ph_r;
  logic [6:0] low_r;
  // 24 cycle period; supply sags only while the drive stays off
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph_r <= 5'h00;
      low_r <= 7'h00;
    end else begin
      ph_r <= (ph_r == 5'h17) ? 5'h00 : ph_r + 5'h01;
      if (gate_drive) begin
        low_r <= 7'h00;
      end else if (low_r != 7'h50) begin
        low_r <= low_r + 7'h01;
      end
    end
  end
  // Pin modes: 1 glitch, 2 long off-time high, 3 high in on-time and blanking
  always_comb begin
    sense.gate_request = ph_r < 5'h06;
    sense.switch_on = gate_drive;
    sense.peak_limit_hit = peak_cmd;
    sense.overvoltage_detect = (pin_mode == 2'h1 && ph_r == 5'h0F)
      || (pin_mode == 2'h2 && ph_r >= 5'h0E && ph_r <= 5'h13)
      || (pin_mode == 2'h3 && ph_r >= 5'h04 && ph_r <= 5'h0A);
    sense.supply_overvoltage = supov_cmd;
    sense.supply_undervoltage_lockout = lockout_cmd;
    sense.supply_stop_level = low_r >= 7'h28 && low_r < 7'h50;
    sense.supply_turnon_level = low_r == 7'h50;
  end
  assign cycle_start = ph_r == 5'h00;
endmodule : power_stage_model
`default_nettype wire

// >>> sim/fault_autorecovery_sequencer_tb_top.sv
// Testbench for the sequencer with the power stage model and a counting model.
// Assumes shortened timing parameters; drive bits are read by packed index.
`timescale 1ns/1ps
`default_nettype none
module fault_autorecovery_sequencer_tb_top;
  // ----
  // Bench
  // ----
  localparam int FC = 50;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic peak = 1'b0;
  logic lockout = 1'b0;
  logic supov = 1'b0;
  logic [1:0] pmode = 2'h0;
  logic cs;
  logic seen;
  logic [31:0] lfsr = 32'h5A4B;
  logic [11:0] pats [5] = '{12'hA6A, 12'hAEA, 12'h2A8, 12'hA2A, 12'hFFF};
  int miscompares = 0;
  int total_checks = 0;
  recovery_pkg::sense_type sn;
  recovery_pkg::drive_type dv;
  power_stage_model i_model (.clk(CLK), .rst_n(RST_N), .gate_drive(dv.gate_drive),
    .peak_cmd(peak), .lockout_cmd(lockout), .supov_cmd(supov), .pin_mode(pmode),
    .sense(sn), .cycle_start(cs));
  fault_autorecovery_sequencer #(.FAULT_CYC(FC), .SOFT_CYC(20), .BLANK_CYC(3),
    .VALID_CYC(2), .OV_DELAY_CYC(5)) i_dut (.CLK(CLK), .RST_N(RST_N),
    .GATE_REQUEST(sn.gate_request), .SWITCH_ON(sn.switch_on),
    .PEAK_LIMIT_HIT(sn.peak_limit_hit), .PROTECTION_SENSE_PIN(sn.overvoltage_detect),
    .SUPPLY_OVERVOLTAGE(sn.supply_overvoltage),
    .SUPPLY_UNDERVOLTAGE_LOCKOUT(sn.supply_undervoltage_lockout),
    .SUPPLY_STOP_LEVEL(sn.supply_stop_level), .SUPPLY_TURNON_LEVEL(sn.supply_turnon_level),
    .GATE_DRIVE(dv.gate_drive), .RAMP_CONNECT(dv.ramp_connect), .SOFT_START(dv.soft_start),
    .OVERLOAD_ERROR(dv.overload_error), .RECOVERY_ACTIVE(dv.recovery_active));
  initial begin
    forever #25 CLK = ~CLK;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic check(input string name, input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask : check
  // Bounded wait on one drive bit (4 gate, 3 ramp, 2 soft, 1 error, 0 recovery)
  task automatic wait_bit(input string name, input int idx, input logic want, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      #1;
      if (dv[idx] === want) break;
    end
    check(name, dv[idx], want);
  endtask : wait_bit
  // A restart must wait for the supply to sag and come back
  task automatic recover();
    logic early;
    early = 1'b0;
    check("gate_stopped", dv.gate_drive, 1'b0);
    // Stay stopped until the supply model is back at the turn-on level
    for (int i = 0; i < 150 && sn.supply_turnon_level !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
      early |= dv.soft_start | !dv.recovery_active;
    end
    check("no_early_restart", early, 1'b0);
    wait_bit("restart_soft", 2, 1'b1, 6);
    wait_bit("run_reached", 2, 1'b0, 60);
  endtask : recover
  task automatic conclude();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Watchdog sized well above the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge CLK);
    miscompares++;
    conclude();
  end
  initial begin
    int cnt;
    int rc;
    int gc;
    int rb;
    logic exp;
    logic [1:0] m;
    repeat (10) @(posedge CLK);
    check("outputs_in_reset", logic'(dv === 5'h00), 1'b1);
    RST_N <= 1'b1;
    wait_bit("first_soft", 2, 1'b1, 200);
    wait_bit("first_run", 2, 1'b0, 60);
    rc = 0;
    gc = 0;
    rb = 0;
    // The sensed on-time lags the drive, so the ramp is a subset of the pulse
    repeat (24) begin
      @(posedge CLK);
      rc += int'(dv.ramp_connect);
      gc += int'(dv.gate_drive);
      rb += int'(dv.ramp_connect && !dv.gate_drive);
    end
    check("ramp_on_time", logic'(rb == 0 && rc > 0 && gc > 0), 1'b1);
    // Overloads shorter than the fault time must not stop the drive
    repeat (2) begin
      @(posedge CLK);
      peak <= 1'b1;
      wait_bit("overload_flag", 1, 1'b1, 6);
      repeat (int'(lfsr[4:0]) + 5) @(posedge CLK);
      lfsr = lfsr_next(lfsr);
      peak <= 1'b0;
      wait_bit("overload_clear", 1, 1'b0, 6);
      check("short_overload", dv.recovery_active, 1'b0);
    end
    @(posedge CLK);
    peak <= 1'b1;
    repeat (FC) @(posedge CLK);
    #1;
    check("timer_not_early", dv.recovery_active, 1'b0);
    wait_bit("timer_stop", 0, 1'b1, 5);
    check("ramp_off", dv.ramp_connect, 1'b0);
    @(posedge CLK);
    peak <= 1'b0;
    recover();
    // Pin patterns against a consecutive-event counting model
    for (int p = 0; p < 6; p++) begin
      cnt = 0;
      exp = 1'b0;
      seen = 1'b0;
      for (int k = 0; k < 8; k++) begin
        m = (k > 5) ? 2'h0 : (p < 5) ? pats[p][2*k +: 2] : lfsr[1:0];
        lfsr = lfsr_next(lfsr);
        do begin
          @(posedge CLK);
          seen |= dv.recovery_active;
        end while (cs !== 1'b1);
        pmode <= m;
        cnt = (m == 2'h2) ? cnt + 1 : 0;
        if (cnt == 4) exp = 1'b1;
      end
      check("pin_trip", seen, exp);
      if (exp) recover();
    end
    @(posedge CLK);
    lockout <= 1'b1;
    wait_bit("lockout_stop", 0, 1'b1, 6);
    @(posedge CLK);
    lockout <= 1'b0;
    recover();
    @(posedge CLK);
    supov <= 1'b1;
    repeat (4) @(posedge CLK);
    supov <= 1'b0;
    repeat (10) @(posedge CLK);
    check("supov_short", dv.recovery_active, 1'b0);
    supov <= 1'b1;
    wait_bit("supov_stop", 0, 1'b1, 12);
    repeat (200) @(posedge CLK);
    check("supov_blocks", dv.soft_start, 1'b0);
    supov <= 1'b0;
    wait_bit("supov_resume", 2, 1'b1, 20);
    conclude();
  end
endmodule : fault_autorecovery_sequencer_tb_top
`default_nettype wire
